/* File: core/asr_pkg.sv */
// Overview of operation
// - temperature register is read-only signed 8-bit, rising with die temperature
// - status register read-only; bits 7,5,4,0 are flags, others read zero
// - data error flag set by parity or fuse margin fault; only reset clears
// - init flag set from reset release until initialization completes, then self-clears
// - temperature fault flag set on limit excess; clear-error clears it once fault gone
// - reset flag set during initialization; cleared only by clear-error write
// - free-running 8-bit count advances every 32 oscillator cycles, wraps at 2.048 ms
// - result registers freeze while capture-hold is high or chip select is low
// - 11-bit result per axis: low byte bits 7:0, high byte bits 10:8
// - reading a low byte suspends updates of both axes until each low byte read has had its high byte read
// - internal reset held after power-on and reasserted on low supply voltage
// - a 4.0 MHz oscillator times the block; dividers derive slower enables
// - regulator switched off 2.0 us in every 249.5 us period to check capacitor
// - both pulse-code outputs driven low while the device is held in reset
// - oscillator fault declared when reference and main clocks differ by over 10%
// - oscillator fault forces serial data out high whenever chip select is low
// - internal reset from power-on, low voltage, pin sequence, or register sequence
// - serial clock high with chip select low for 512 us forces reset
// - three ordered control writes 10,11,01 reset; a 00 write aborts
// - clear-error bit clears transient error status and always reads zero
package asr_pkg;
  localparam logic [6:0] ADDR_TEMP = 7'h0F;
  localparam logic [6:0] ADDR_STAT = 7'h10;
  localparam logic [6:0] ADDR_TICK = 7'h11;
  localparam logic [6:0] ADDR_XL = 7'h24;
  localparam logic [6:0] ADDR_XH = 7'h25;
  localparam logic [6:0] ADDR_YL = 7'h26;
  localparam logic [6:0] ADDR_YH = 7'h27;
  localparam logic [6:0] ADDR_CTRL = 7'h0E;
  localparam int BIT_IDE = 7;
  localparam int BIT_INIT = 5;
  localparam int BIT_TF = 4;
  localparam int BIT_RES = 0;
  localparam int BIT_UPPER_RESET_BIT = 7;
  localparam int BIT_LOWER_RESET_BIT = 6;
  localparam int BIT_CE = 5;
  localparam int BIT_PCMEN = 4;
  localparam int CLK_MHZ = 100;
  localparam int OSC_KHZ = 4000;
  localparam int PRESCALE_DIV = 32;
  localparam int OSC_DIV = CLK_MHZ * 1000 / OSC_KHZ;
  localparam int CREG_OFF_NS = 2000;
  localparam int CREG_PERIOD_NS = 249500;
  localparam int CREG_OFF_CYC = CREG_OFF_NS * CLK_MHZ / 1000;
  localparam int CREG_PERIOD_CYC = CREG_PERIOD_NS * CLK_MHZ / 1000;
  localparam int PIN_RST_US = 512;
  localparam int PIN_RST_CYC = PIN_RST_US * CLK_MHZ;
  localparam int INIT_CYC_DEF = 1000;
  localparam int OSC_WIN = 256;
  localparam int OSC_TOL_PCT = 10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } asr_req_t;
  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
  } asr_acc_t;
endpackage

/* File: core/asr_regs.sv */
`timescale 1ns/100ps
module asr_regs #(
  parameter int PIN_RST_CYCLES = asr_pkg::PIN_RST_CYC,
  parameter int CREG_PERIOD = asr_pkg::CREG_PERIOD_CYC,
  parameter int INIT_CYCLES = asr_pkg::INIT_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic capture_hold_input_pin,
  input wire logic ref_osc_tick,
  input wire asr_pkg::asr_req_t req,
  input wire asr_pkg::asr_acc_t acc_in,
  input wire logic [7:0] temp_in,
  input wire logic temp_limit_fault,
  input wire logic parity_fault,
  input wire logic fuse_margin_fault,
  input wire logic pcm_x_in,
  input wire logic pcm_y_in,
  output logic [7:0] rdata,
  output logic dout_force_high,
  output logic regulator_en,
  output logic pcm_x,
  output logic pcm_y,
  output logic internal_reset
);
  import asr_pkg::*;

  function automatic logic hit(input asr_req_t r, input logic [6:0] a);
    return r.sel && r.addr == a;
  endfunction

  // two-flop synchronisers for pin inputs
  logic [1:0] s_supply, s_sclk, s_cs, s_hold, s_ref;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_supply <= 2'h0;
      s_sclk <= 2'h0;
      s_cs <= 2'h3;
      s_hold <= 2'h0;
      s_ref <= 2'h0;
    end else begin
      s_supply <= {s_supply[0], supply_ok};
      s_sclk <= {s_sclk[0], sclk_pin};
      s_cs <= {s_cs[0], cs_n_pin};
      s_hold <= {s_hold[0], capture_hold_input_pin};
      s_ref <= {s_ref[0], ref_osc_tick};
    end
  end
  wire logic supply_s = s_supply[1];
  wire logic sclk_s = s_sclk[1];
  wire logic cs_n_s = s_cs[1];
  wire logic hold_s = s_hold[1];

  // state
  logic ires, next_ires;
  logic [31:0] pin_cnt, next_pin_cnt;
  logic [1:0] seq, next_seq;
  logic [31:0] init_cnt, next_init_cnt;
  logic init_flag, next_init_flag;
  logic res_flag, next_res_flag;
  logic internal_data_error_flag, next_ide;
  logic tf, next_tf;
  logic [4:0] osc_div, next_osc_div;
  logic [4:0] pre, next_pre;
  logic [7:0] tick, next_tick;
  asr_acc_t acc, next_acc;
  logic lock_x, next_lock_x, lock_y, next_lock_y;
  logic [31:0] creg_cnt, next_creg_cnt;
  logic [9:0] win_cnt, next_win_cnt;
  logic [9:0] ref_cnt, next_ref_cnt;
  logic ref_prev, next_ref_prev;
  logic oscf, next_oscf;
  logic [7:0] next_rdata;
  logic next_pcm_x, next_pcm_y, next_dout_hi, next_reg_en;
  logic pcm_en, next_pcm_en;

  wire logic wr_ctrl = req.wr && hit(req, ADDR_CTRL);
  wire logic ce_wr = wr_ctrl && req.wdata[BIT_CE];
  wire logic [1:0] resb = {req.wdata[BIT_UPPER_RESET_BIT], req.wdata[BIT_LOWER_RESET_BIT]};
  wire logic osc_tick = osc_div == 5'(OSC_DIV - 1);

  always_comb begin
    next_ires = 1'b0;
    next_seq = seq;
    next_pin_cnt = 32'h0;
    if (!cs_n_s && sclk_s) begin
      next_pin_cnt = pin_cnt + 32'h1;
    end
    if (wr_ctrl) begin
      case (resb)
        2'h2: next_seq = 2'h1;
        2'h3: next_seq = (seq == 2'h1) ? 2'h2 : 2'h0;
        2'h1: next_seq = (seq == 2'h2) ? 2'h3 : 2'h0;
        default: next_seq = 2'h0;
      endcase
    end
    if (!supply_s || pin_cnt >= 32'(PIN_RST_CYCLES) || seq == 2'h3) begin
      next_ires = 1'b1;
      next_seq = 2'h0;
      next_pin_cnt = 32'h0;
    end
  end

  always_comb begin
    next_init_cnt = init_cnt;
    next_init_flag = init_flag;
    next_res_flag = res_flag;
    next_ide = internal_data_error_flag | parity_fault | fuse_margin_fault;
    next_tf = tf | temp_limit_fault;
    next_pcm_en = pcm_en;
    if (wr_ctrl) begin
      next_pcm_en = req.wdata[BIT_PCMEN];
    end
    if (init_flag) begin
      next_res_flag = 1'b1;
      if (init_cnt >= 32'(INIT_CYCLES - 1)) begin
        next_init_flag = 1'b0;
      end else begin
        next_init_cnt = init_cnt + 32'h1;
      end
    end else if (ce_wr) begin
      next_res_flag = 1'b0;
    end
    if (ce_wr && !temp_limit_fault) begin
      next_tf = 1'b0;
    end
    if (ires) begin
      next_init_cnt = 32'h0;
      next_init_flag = 1'b1;
      next_res_flag = 1'b1;
      next_ide = 1'b0;
      next_tf = 1'b0;
      next_pcm_en = 1'b0;
    end
  end

  always_comb begin
    next_osc_div = osc_tick ? 5'h0 : osc_div + 5'h1;
    next_pre = pre;
    next_tick = tick;
    if (osc_tick) begin
      next_pre = pre + 5'h1;
      if (pre == 5'(PRESCALE_DIV - 1)) begin
        next_tick = tick + 8'h1;
      end
    end
    if (ires) begin
      next_osc_div = 5'h0;
      next_pre = 5'h0;
      next_tick = 8'h0;
    end
  end

  // result freeze and byte-pair lock
  always_comb begin
    next_acc = acc;
    next_lock_x = lock_x;
    next_lock_y = lock_y;
    if (req.rd && hit(req, ADDR_XL)) next_lock_x = 1'b1;
    if (req.rd && hit(req, ADDR_YL)) next_lock_y = 1'b1;
    if (req.rd && hit(req, ADDR_XH)) next_lock_x = 1'b0;
    if (req.rd && hit(req, ADDR_YH)) next_lock_y = 1'b0;
    if (!hold_s && cs_n_s && !lock_x && !lock_y) begin
      next_acc = acc_in;
    end
    if (ires) begin
      next_acc = '0;
      next_lock_x = 1'b0;
      next_lock_y = 1'b0;
    end
  end

  // read mux; writes to read-only addresses fall through untouched
  always_comb begin
    next_rdata = rdata;
    if (req.rd && req.sel) begin
      case (req.addr)
        ADDR_TEMP: next_rdata = temp_in;
        ADDR_STAT: begin
          next_rdata = RESET_BYTE;
          next_rdata[BIT_IDE] = internal_data_error_flag;
          next_rdata[BIT_INIT] = init_flag;
          next_rdata[BIT_TF] = tf;
          next_rdata[BIT_RES] = res_flag;
        end
        ADDR_TICK: next_rdata = tick;
        ADDR_XL: next_rdata = acc.x[7:0];
        ADDR_XH: next_rdata = {5'h0, acc.x[10:8]};
        ADDR_YL: next_rdata = acc.y[7:0];
        ADDR_YH: next_rdata = {5'h0, acc.y[10:8]};
        ADDR_CTRL: next_rdata = {3'h0, pcm_en, 4'h0};
        default: next_rdata = RESET_BYTE;
      endcase
    end
  end

  // count reference edges over a window of main ticks
  always_comb begin
    next_ref_prev = s_ref[1];
    next_ref_cnt = ref_cnt;
    next_win_cnt = win_cnt;
    next_oscf = oscf;
    if (s_ref[1] && !ref_prev) next_ref_cnt = ref_cnt + 10'h1;
    if (osc_tick) begin
      next_win_cnt = win_cnt + 10'h1;
      if (win_cnt == 10'(OSC_WIN - 1)) begin
        next_win_cnt = 10'h0;
        next_ref_cnt = 10'h0;
        // full width, so the tolerance products cannot wrap
        if (32'(ref_cnt) * 32'h64 > 32'(OSC_WIN * (100 + OSC_TOL_PCT))
            || 32'(ref_cnt) * 32'h64 < 32'(OSC_WIN * (100 - OSC_TOL_PCT)))
          next_oscf = 1'b1;
      end
    end
    if (ires) begin
      next_win_cnt = 10'h0;
      next_ref_cnt = 10'h0;
      next_oscf = 1'b0;
    end
  end

  // regulator off at the tail of each check period
  always_comb begin
    next_creg_cnt = (creg_cnt >= 32'(CREG_PERIOD - 1)) ? 32'h0
                                                     : creg_cnt + 32'h1;
    next_reg_en = creg_cnt < 32'(CREG_PERIOD - CREG_OFF_CYC);
    next_dout_hi = oscf && !cs_n_s;
    next_pcm_x = pcm_en && pcm_x_in && !ires && !init_flag;
    next_pcm_y = pcm_en && pcm_y_in && !ires && !init_flag;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ires <= 1'b1;
      seq <= 2'h0;
      pin_cnt <= 32'h0;
      init_cnt <= 32'h0;
      init_flag <= 1'b1;
      res_flag <= 1'b1;
      internal_data_error_flag <= 1'b0;
      tf <= 1'b0;
      pcm_en <= 1'b0;
      osc_div <= 5'h0;
      pre <= 5'h0;
      tick <= 8'h0;
      acc <= '0;
      lock_x <= 1'b0;
      lock_y <= 1'b0;
      rdata <= 8'h0;
      ref_prev <= 1'b0;
      ref_cnt <= 10'h0;
      win_cnt <= 10'h0;
      oscf <= 1'b0;
      creg_cnt <= 32'h0;
      regulator_en <= 1'b1;
      dout_force_high <= 1'b0;
      pcm_x <= 1'b0;
      pcm_y <= 1'b0;
    end else begin
      ires <= next_ires;
      seq <= next_seq;
      pin_cnt <= next_pin_cnt;
      init_cnt <= next_init_cnt;
      init_flag <= next_init_flag;
      res_flag <= next_res_flag;
      internal_data_error_flag <= next_ide;
      tf <= next_tf;
      pcm_en <= next_pcm_en;
      osc_div <= next_osc_div;
      pre <= next_pre;
      tick <= next_tick;
      acc <= next_acc;
      lock_x <= next_lock_x;
      lock_y <= next_lock_y;
      rdata <= next_rdata;
      ref_prev <= next_ref_prev;
      ref_cnt <= next_ref_cnt;
      win_cnt <= next_win_cnt;
      oscf <= next_oscf;
      creg_cnt <= next_creg_cnt;
      regulator_en <= next_reg_en;
      dout_force_high <= next_dout_hi;
      pcm_x <= next_pcm_x;
      pcm_y <= next_pcm_y;
    end
  end
  assign internal_reset = ires;
endmodule

/* File: test/asr_regs_asserts.sv */
`timescale 1ns/100ps
module asr_regs_asserts #(
  parameter int PIN_RST_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic [7:0] temp_in,
  input wire asr_pkg::asr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic dout_force_high,
  input wire logic regulator_en,
  input wire logic pcm_x,
  input wire logic pcm_y,
  input wire logic internal_reset
);
  import asr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_en;
  int off_cnt, pin_cnt, next_off_cnt, next_pin_cnt;
  assign rd_en = req.sel && req.rd;
  always_comb begin
    next_off_cnt = regulator_en ? 0 : off_cnt + 1;
    next_pin_cnt = (sclk_pin && !cs_n_pin) ? pin_cnt + 1 : 0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt <= 0;
      pin_cnt <= 0;
    end else begin
      off_cnt <= next_off_cnt;
      pin_cnt <= next_pin_cnt;
    end
  end
  stat_zeros_a: assert property (
    rd_en && req.addr == ADDR_STAT |=> (rdata & 8'h4E) == 8'h00)
    else $error("status unused bits set");
  high_zero_a: assert property (
    rd_en && (req.addr == ADDR_XH || req.addr == ADDR_YH)
    |=> rdata[7:3] == 5'h00) else $error("high byte upper bits set");
  temp_read_a: assert property (
    rd_en && req.addr == ADDR_TEMP && $stable(temp_in)
    |=> rdata == $past(temp_in)) else $error("temperature read wrong");
  ctrl_zeros_a: assert property (
    rd_en && req.addr == ADDR_CTRL |=> rdata[7:5] == 3'h0)
    else $error("control command bits read back");
  low_supply_a: assert property (!supply_ok |-> ##[1:3] internal_reset)
    else $error("no reset on low supply");
  pcm_low_a: assert property (internal_reset |=> !pcm_x && !pcm_y)
    else $error("pcm driven during reset");
  dout_cs_a: assert property (cs_n_pin [*4] |=> !dout_force_high)
    else $error("data out forced while deselected");
  reg_off_a: assert property (
    $rose(regulator_en) |-> off_cnt == CREG_OFF_CYC)
    else $error("regulator off time wrong");
  pin_rst_a: assert property (
    pin_cnt == PIN_RST_CYCLES |-> ##[0:4] internal_reset)
    else $error("pin reset not taken");
  cover property (rd_en && req.addr == ADDR_XL);
  cover property ($rose(dout_force_high));
  cover property ($rose(internal_reset));
endmodule
bind asr_regs asr_regs_asserts #(.PIN_RST_CYCLES(PIN_RST_CYCLES))
  u_asr_regs_asserts (.*);

/* File: test/asr_host.sv */
`timescale 1ns/100ps
module asr_host (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output asr_pkg::asr_req_t req
);
  import asr_pkg::*;
  initial req = '0;
  // strobe lasts one cycle; the next call waits a further falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    req <= '{1'b1, 1'b0, 1'b1, a, v};
    @(negedge sys_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    req <= '{1'b1, 1'b1, 1'b0, a, 8'h00};
    @(negedge sys_clk);
    req <= '0;
    @(negedge sys_clk);
    v = rdata;
  endtask
endmodule

/* File: test/accel_status_result_regs_bench.sv */
`timescale 1ns/100ps
module accel_status_result_regs_bench;
  import asr_pkg::*;
  logic sys_clk, rst_n, supply_ok, sclk_pin, cs_n_pin, capture_hold_input_pin;
  logic ref_osc_tick, temp_limit_fault, parity_fault, fuse_margin_fault;
  logic pcm_x_in, pcm_y_in, dout_force_high, regulator_en, pcm_x, pcm_y;
  logic internal_reset;
  logic [7:0] rdata, temp_in, d;
  asr_req_t req;
  asr_acc_t acc_in;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int ref_half = 125;
  asr_regs #(.PIN_RST_CYCLES(50), .CREG_PERIOD(2000), .INIT_CYCLES(20))
    u_asr_regs (.*);
  asr_host u_asr_host (.sys_clk(sys_clk), .rdata(rdata), .req(req));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    ref_osc_tick = 0;
    forever #(ref_half) ref_osc_tick = ~ref_osc_tick;
  end
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // whole run is about 22k cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      give_verdict;
    end
  end
  task automatic check(string w, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", w, exp, seen);
    end
  endtask
  task automatic rdc(string w, logic [6:0] a, logic [7:0] m, logic [7:0] e);
    u_asr_host.rd(a, d);
    check(w, d & m, e);
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    {rst_n, sclk_pin, capture_hold_input_pin, temp_limit_fault, parity_fault} = '0;
    {fuse_margin_fault, pcm_x_in, pcm_y_in} = '0;
    {supply_ok, cs_n_pin} = 2'h3;
    temp_in = 8'h85;
    acc_in = {11'h5A3, 11'h2C7};
    wt(2);
    rst_n = 1;
    wt(6);
    rdc("init", ADDR_STAT, 8'h20, 8'h20);
    wt(30);
    rdc("stat", ADDR_STAT, 8'hFF, 8'h01);
    u_asr_host.wr(ADDR_CTRL, 8'h20);
    rdc("clr", ADDR_STAT, 8'hFF, 8'h00);
    rdc("ctrl", ADDR_CTRL, 8'hE0, 8'h00);
    u_asr_host.wr(ADDR_TEMP, 8'h00);
    rdc("temp", ADDR_TEMP, 8'hFF, 8'h85);
    temp_limit_fault = 1;
    wt(3);
    u_asr_host.wr(ADDR_CTRL, 8'h20);
    rdc("tf_on", ADDR_STAT, 8'h10, 8'h10);
    temp_limit_fault = 0;
    u_asr_host.wr(ADDR_CTRL, 8'h20);
    rdc("tf_off", ADDR_STAT, 8'h10, 8'h00);
    rdc("xl", ADDR_XL, 8'hFF, 8'hA3);
    acc_in = {11'h123, 11'h456};
    wt(4);
    rdc("xh_lock", ADDR_XH, 8'hFF, 8'h05);
    wt(4);
    rdc("yl", ADDR_YL, 8'hFF, 8'h56);
    rdc("yh", ADDR_YH, 8'hFF, 8'h04);
    capture_hold_input_pin = 1;
    // hold must pass the synchroniser before new results appear
    wt(3);
    acc_in = {11'h7FF, 11'h001};
    wt(4);
    rdc("hold", ADDR_XL, 8'hFF, 8'h23);
    rdc("hold_h", ADDR_XH, 8'hFF, 8'h01);
    {capture_hold_input_pin, cs_n_pin} = 2'h0;
    wt(4);
    rdc("cs_lo", ADDR_XL, 8'hFF, 8'h23);
    rdc("cs_lo_h", ADDR_XH, 8'hFF, 8'h01);
    cs_n_pin = 1;
    wt(4);
    rdc("upd", ADDR_XL, 8'hFF, 8'hFF);
    rdc("upd_h", ADDR_XH, 8'hFF, 8'h07);
    u_asr_host.rd(ADDR_TICK, d);
    temp_in = d + 8'h01;
    wt(797);
    rdc("tick", ADDR_TICK, 8'hFF, temp_in);
    temp_in = 8'h85;
    u_asr_host.wr(ADDR_CTRL, 8'h80);
    u_asr_host.wr(ADDR_CTRL, 8'h00);
    u_asr_host.wr(ADDR_CTRL, 8'hC0);
    u_asr_host.wr(ADDR_CTRL, 8'h40);
    rdc("abort", ADDR_STAT, 8'hFF, 8'h00);
    u_asr_host.wr(ADDR_CTRL, 8'h80);
    u_asr_host.wr(ADDR_CTRL, 8'hC0);
    u_asr_host.wr(ADDR_CTRL, 8'h40);
    wt(3);
    rdc("seq_rst", ADDR_STAT, 8'h21, 8'h21);
    wt(30);
    u_asr_host.wr(ADDR_CTRL, 8'h30);
    pcm_x_in = 1;
    wt(4);
    check("pcm_on", {7'h00, pcm_x}, 8'h01);
    {sclk_pin, cs_n_pin} = 2'h2;
    wt(55);
    check("pcm_rst", {7'h00, pcm_x}, 8'h00);
    {sclk_pin, cs_n_pin} = 2'h1;
    wt(3);
    rdc("pin_rst", ADDR_STAT, 8'h21, 8'h21);
    supply_ok = 0;
    wt(5);
    check("low_v", {7'h00, internal_reset}, 8'h01);
    supply_ok = 1;
    wt(40);
    u_asr_host.wr(ADDR_CTRL, 8'h20);
    parity_fault = 1;
    wt(2);
    parity_fault = 0;
    u_asr_host.wr(ADDR_CTRL, 8'h20);
    rdc("ide", ADDR_STAT, 8'h80, 8'h80);
    wt(7000);
    cs_n_pin = 0;
    wt(3);
    check("osc_ok", {7'h00, dout_force_high}, 8'h00);
    cs_n_pin = 1;
    // a slow reference can take up to two compare windows to show
    ref_half = 180;
    wt(14000);
    cs_n_pin = 0;
    wt(3);
    check("osc_f", {7'h00, dout_force_high}, 8'h01);
    cs_n_pin = 1;
    wt(5);
    check("osc_cs", {7'h00, dout_force_high}, 8'h00);
    give_verdict;
  end
endmodule
